/* logic/qdsc_pkg.sv */
// Purpose: Shared constants and types for the quad DAC serial control block
// Assumes: Command word is 4-bit command, 4-bit address, 16-bit data
// Notes:   Only the digital control side of the converter is modelled
package qdsc_pkg;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  localparam int SPAN_W = 4;
  localparam int CNT_W  = 6;

  // Positions of command, address and data in the last 24 bits shifted
  localparam int CMD_LSB  = 20;
  localparam int ADDR_LSB = 16;
  localparam int WORD_W   = 24;
  localparam int SHIFT_W  = 32;

  // Position of the sleep status bit in a span readback word
  localparam int SLEEP_BIT_POS = 4;

  localparam logic [3:0] CMD_WR_SPAN    = 4'h2;
  localparam logic [3:0] CMD_WR_CODE    = 4'h3;
  localparam logic [3:0] CMD_UPD_N      = 4'h4;
  localparam logic [3:0] CMD_UPD_ALL    = 4'h5;
  localparam logic [3:0] CMD_WS_UPD_N   = 4'h6;
  localparam logic [3:0] CMD_WC_UPD_N   = 4'h7;
  localparam logic [3:0] CMD_WS_UPD_ALL = 4'h8;
  localparam logic [3:0] CMD_WC_UPD_ALL = 4'h9;
  localparam logic [3:0] CMD_RD_B1_SPAN = 4'ha;
  localparam logic [3:0] CMD_RD_B1_CODE = 4'hb;
  localparam logic [3:0] CMD_RD_B2_SPAN = 4'hc;
  localparam logic [3:0] CMD_RD_B2_CODE = 4'hd;
  localparam logic [3:0] CMD_SLEEP      = 4'he;
  localparam logic [3:0] CMD_NOP        = 4'hf;

  localparam logic [3:0] ADDR_A   = 4'h0;
  localparam logic [3:0] ADDR_B   = 4'h2;
  localparam logic [3:0] ADDR_C   = 4'h4;
  localparam logic [3:0] ADDR_D   = 4'h6;
  localparam logic [3:0] ADDR_ALL = 4'hf;

  localparam logic [SPAN_W-1:0] SPAN_RESET = 4'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [NUM_CH-1:0] MASK_ALL   = 4'hf;
  localparam logic [NUM_CH-1:0] MASK_NONE  = 4'h0;

  // Bit counts of a frame and of its command/address header
  localparam logic [CNT_W-1:0] FRAME_LEN_24 = 6'h18;
  localparam logic [CNT_W-1:0] FRAME_LEN_32 = 6'h20;
  localparam logic [CNT_W-1:0] HDR_LEN_24   = 6'h08;
  localparam logic [CNT_W-1:0] HDR_LEN_32   = 6'h10;
  localparam logic [CNT_W-1:0] CNT_MAX      = 6'h3f;

  // Synchroniser lanes
  localparam int SYNC_W   = 7;
  localparam int SY_SCK   = 0;
  localparam int SY_SDI   = 1;
  localparam int SY_CS    = 2;
  localparam int SY_ASYNC_UPDATE_PIN_N  = 3;
  localparam int SY_CLR   = 4;
  localparam int SY_VDD   = 5;
  localparam int SY_F32   = 6;

  typedef enum logic [1:0] {RB_B1_SPAN, RB_B1_CODE, RB_B2_SPAN, RB_B2_CODE} qdsc_rbsel_t;
  typedef enum logic [1:0] {FS_IDLE, FS_SHIFT, FS_ABORT} qdsc_frame_t;
endpackage : qdsc_pkg

/* logic/qdsc_top.sv */
// Purpose: Serial command decoder, buffers, sleep and readback of a quad DAC
// Assumes: Serial clock, data, strobe and pins are asynchronous and sampled
// Notes:   Readback pin is split into data and enable
// How it works
// - Power-up sets every channel span to code 0000, the 0-5 V range.
// - Power-up clears all holding and active code and span buffers to zero.
// - Clear low zeroes shift register, counter and all active buffers.
// - Clear keeps holding buffers so a later update restores outputs.
// - Clear during a low strobe abandons the frame in progress.
// - Data-loss flag goes low at power-up, clear and logic supply dip.
// - Data-loss flag stays low until a valid update executes.
// - Command 1110 puts the addressed channels to sleep.
// - Pair reference amplifier powers down only when both its channels sleep.
// - Span readback carries the sleep status as the fifth least bit.
// - Frame is command, address, data; 0010 with 1111 writes all spans.
// - Span write to address 0000 changes only channel A holding span.
// - Command 0011 writes the 16-bit field to the holding code buffers.
// - Command 0100 to all channels copies holding into active buffers.
// - A low load-pin pulse with strobe high copies holding into active for all channels.
// - 32-bit frame has eight leading bits before command and address.
// - Write frames shift out the buffer chosen by the previous command.
// - Read commands shift the addressed buffer out in the same frame.
// - Active buffers change only by an update from holding buffers or by a clear.
// - Readback pin floats while strobe high and drives low until data.
// - Any update, load pin included, wakes the addressed channels.
module qdsc_top
  import qdsc_pkg::*;
(
  input  wire logic              CORE_CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              SCK_I,
  input  wire logic              SDI_I,
  input  wire logic              SELECT_LOAD_STROBE_N_I,
  input  wire logic              ASYNC_UPDATE_PIN_N_I,
  input  wire logic              SYSTEM_CLEAR_N_I,
  input  wire logic              VDD_LOW_I,
  input  wire logic              FRAME_32_I,
  output logic                   SERIAL_READBACK_OUT_O,
  output logic                   SERIAL_READBACK_OE_O,
  output logic                   DATA_LOSS_FLAG_N_O,
  output logic [CODE_W-1:0]      ACT_CODE_A_O,
  output logic [CODE_W-1:0]      ACT_CODE_B_O,
  output logic [CODE_W-1:0]      ACT_CODE_C_O,
  output logic [CODE_W-1:0]      ACT_CODE_D_O,
  output logic [SPAN_W-1:0]      ACT_SPAN_A_O,
  output logic [SPAN_W-1:0]      ACT_SPAN_B_O,
  output logic [SPAN_W-1:0]      ACT_SPAN_C_O,
  output logic [SPAN_W-1:0]      ACT_SPAN_D_O,
  output logic [NUM_CH-1:0]      CH_SLEEP_O,
  output logic                   REF_AMP_AB_PD_O,
  output logic                   REF_AMP_CD_PD_O
);

  logic [SYNC_W-1:0]  sync1_reg;
  logic [SYNC_W-1:0]  sync2_reg;
  logic [SYNC_W-1:0]  sync3_reg;
  logic               sck_rise;
  logic               sck_fall;
  logic               cs_fall;
  logic               cs_rise;
  logic               cs_low;
  logic               async_update_pin_n_fall;
  logic               clr_act;
  logic               vdd_low;
  logic               frame32;

  qdsc_frame_t        frame_reg;
  logic [SHIFT_W-1:0] shift_reg;
  logic [SHIFT_W-1:0] shift_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic [CNT_W-1:0]   frame_len;
  logic [CNT_W-1:0]   hdr_len;

  logic [CODE_W-1:0]  hold_code_reg [NUM_CH];
  logic [SPAN_W-1:0]  hold_span_reg [NUM_CH];
  logic [CODE_W-1:0]  act_code_reg  [NUM_CH];
  logic [SPAN_W-1:0]  act_span_reg  [NUM_CH];
  logic [NUM_CH-1:0]  sleep_reg;
  logic               flag_n_reg;

  logic [3:0]         cmd;
  logic [3:0]         addr;
  logic [CODE_W-1:0]  data;
  logic               addr_ok;
  logic               cmd_ok;
  logic               exec;
  logic [NUM_CH-1:0]  addr_mask;
  logic [NUM_CH-1:0]  wr_span_mask;
  logic [NUM_CH-1:0]  wr_code_mask;
  logic [NUM_CH-1:0]  upd_mask;
  logic [NUM_CH-1:0]  sleep_mask;
  logic               upd_any;
  qdsc_rbsel_t        ptr_sel_next;

  qdsc_rbsel_t        ptr_sel_reg;
  logic [1:0]         ptr_ch_reg;
  logic [CODE_W-1:0]  rb_reg;
  logic               rb_active_reg;
  logic               sro_reg;
  logic               hdr_done;
  logic [3:0]         hdr_cmd;
  logic [3:0]         hdr_addr;
  logic               hdr_is_read;
  qdsc_rbsel_t        rb_sel;
  logic [1:0]         rb_ch;
  logic [CODE_W-1:0]  rb_word;

  // Two-stage synchronisers, third stage for edges; reset to idle pin levels
  genvar gs;
  generate
    for (gs = 0; gs < SYNC_W; gs++) begin : g_sync
      always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
          sync1_reg[gs] <= (gs == SY_CS) || (gs == SY_ASYNC_UPDATE_PIN_N) || (gs == SY_CLR);
          sync2_reg[gs] <= (gs == SY_CS) || (gs == SY_ASYNC_UPDATE_PIN_N) || (gs == SY_CLR);
          sync3_reg[gs] <= (gs == SY_CS) || (gs == SY_ASYNC_UPDATE_PIN_N) || (gs == SY_CLR);
        end else begin
          sync1_reg[gs] <= (gs == SY_SCK) ? SCK_I :
                           (gs == SY_SDI) ? SDI_I :
                           (gs == SY_CS)  ? SELECT_LOAD_STROBE_N_I :
                           (gs == SY_ASYNC_UPDATE_PIN_N) ? ASYNC_UPDATE_PIN_N_I :
                           (gs == SY_CLR) ? SYSTEM_CLEAR_N_I :
                           (gs == SY_VDD) ? VDD_LOW_I : FRAME_32_I;
          sync2_reg[gs] <= sync1_reg[gs];
          sync3_reg[gs] <= sync2_reg[gs];
        end
      end
    end
  endgenerate

  assign sck_rise  = sync2_reg[SY_SCK] & ~sync3_reg[SY_SCK];
  assign sck_fall  = ~sync2_reg[SY_SCK] & sync3_reg[SY_SCK];
  assign cs_fall   = ~sync2_reg[SY_CS] & sync3_reg[SY_CS];
  assign cs_rise   = sync2_reg[SY_CS] & ~sync3_reg[SY_CS];
  assign cs_low    = ~sync2_reg[SY_CS] & ~sync3_reg[SY_CS];
  assign async_update_pin_n_fall = ~sync2_reg[SY_ASYNC_UPDATE_PIN_N] & sync3_reg[SY_ASYNC_UPDATE_PIN_N] & sync2_reg[SY_CS];
  assign clr_act   = ~sync2_reg[SY_CLR] & ~sync3_reg[SY_CLR];
  assign vdd_low   = sync2_reg[SY_VDD];
  assign frame32   = sync2_reg[SY_F32];

  assign frame_len  = frame32 ? FRAME_LEN_32 : FRAME_LEN_24;
  assign hdr_len    = frame32 ? HDR_LEN_32 : HDR_LEN_24;
  assign shift_next = {shift_reg[SHIFT_W-2:0], sync2_reg[SY_SDI]};
  assign cnt_next   = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 6'h01;

  // Frame tracking and input shift register
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      frame_reg <= FS_IDLE;
      shift_reg <= '0;
      cnt_reg   <= '0;
    end else if (clr_act) begin
      frame_reg <= cs_low ? FS_ABORT : FS_IDLE;
      shift_reg <= '0;
      cnt_reg   <= '0;
    end else begin
      case (frame_reg)
        FS_IDLE: begin
          if (cs_fall) begin
            frame_reg <= FS_SHIFT;
            cnt_reg   <= '0;
          end
        end
        FS_SHIFT: begin
          if (cs_rise) begin
            frame_reg <= FS_IDLE;
          end else if (sck_rise) begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
          end
        end
        FS_ABORT: begin
          if (cs_rise) begin
            frame_reg <= FS_IDLE;
          end
        end
        default: frame_reg <= FS_IDLE;
      endcase
    end
  end

  assign cmd  = shift_reg[CMD_LSB +: 4];
  assign addr = shift_reg[ADDR_LSB +: 4];
  assign data = shift_reg[CODE_W-1:0];

  // Decode of a completed frame at strobe rise
  always_comb begin
    addr_ok      = (addr == ADDR_A) || (addr == ADDR_B) || (addr == ADDR_C) ||
                   (addr == ADDR_D) || (addr == ADDR_ALL);
    addr_mask    = (addr == ADDR_ALL) ? MASK_ALL : (MASK_NONE | (4'h1 << addr[2:1]));
    cmd_ok       = (cmd >= CMD_WR_SPAN);
    exec         = (frame_reg == FS_SHIFT) && cs_rise && !clr_act &&
                   (cnt_reg == frame_len) && addr_ok && cmd_ok;
    wr_span_mask = MASK_NONE;
    wr_code_mask = MASK_NONE;
    upd_mask     = MASK_NONE;
    sleep_mask   = MASK_NONE;
    ptr_sel_next = RB_B2_SPAN;
    case (cmd)
      CMD_WR_SPAN: begin
        wr_span_mask = addr_mask;
        ptr_sel_next = RB_B1_SPAN;
      end
      CMD_WR_CODE: begin
        wr_code_mask = addr_mask;
        ptr_sel_next = RB_B1_CODE;
      end
      CMD_UPD_N: upd_mask = addr_mask;
      CMD_UPD_ALL: begin
        upd_mask     = MASK_ALL;
        ptr_sel_next = RB_B2_CODE;
      end
      CMD_WS_UPD_N: begin
        wr_span_mask = addr_mask;
        upd_mask     = addr_mask;
      end
      CMD_WC_UPD_N: begin
        wr_code_mask = addr_mask;
        upd_mask     = addr_mask;
        ptr_sel_next = RB_B2_CODE;
      end
      CMD_WS_UPD_ALL: begin
        wr_span_mask = addr_mask;
        upd_mask     = MASK_ALL;
      end
      CMD_WC_UPD_ALL: begin
        wr_code_mask = addr_mask;
        upd_mask     = MASK_ALL;
        ptr_sel_next = RB_B2_CODE;
      end
      CMD_RD_B1_SPAN: ptr_sel_next = RB_B1_SPAN;
      CMD_RD_B1_CODE: ptr_sel_next = RB_B1_CODE;
      CMD_RD_B2_SPAN: ptr_sel_next = RB_B2_SPAN;
      CMD_RD_B2_CODE: ptr_sel_next = RB_B2_CODE;
      CMD_SLEEP: sleep_mask = addr_mask;
      CMD_NOP: ptr_sel_next = RB_B2_CODE;
      default: ptr_sel_next = RB_B2_SPAN;
    endcase
    if (!exec) begin
      wr_span_mask = MASK_NONE;
      wr_code_mask = MASK_NONE;
      upd_mask     = MASK_NONE;
      sleep_mask   = MASK_NONE;
    end
    if (async_update_pin_n_fall && !clr_act) begin
      upd_mask = MASK_ALL;
    end
    upd_any = |upd_mask;
  end

  // Per-channel holding, active and sleep state
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      logic [CODE_W-1:0] code_next;
      logic [SPAN_W-1:0] span_next;

      assign code_next = wr_code_mask[gc] ? data : hold_code_reg[gc];
      assign span_next = wr_span_mask[gc] ? data[SPAN_W-1:0] : hold_span_reg[gc];

      // Holding buffers survive a clear
      always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
          hold_code_reg[gc] <= CODE_RESET;
          hold_span_reg[gc] <= SPAN_RESET;
        end else begin
          hold_code_reg[gc] <= code_next;
          hold_span_reg[gc] <= span_next;
        end
      end

      always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
          act_code_reg[gc] <= CODE_RESET;
          act_span_reg[gc] <= SPAN_RESET;
        end else if (clr_act) begin
          act_code_reg[gc] <= CODE_RESET;
          act_span_reg[gc] <= SPAN_RESET;
        end else if (upd_mask[gc]) begin
          act_code_reg[gc] <= code_next;
          act_span_reg[gc] <= span_next;
        end
      end

      always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
          sleep_reg[gc] <= 1'b0;
        end else if (upd_mask[gc]) begin
          sleep_reg[gc] <= 1'b0;
        end else if (sleep_mask[gc]) begin
          sleep_reg[gc] <= 1'b1;
        end
      end
    end
  endgenerate

  // Data-loss flag, assertion has priority over release
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      flag_n_reg <= 1'b0;
    end else if (clr_act || vdd_low) begin
      flag_n_reg <= 1'b0;
    end else if (upd_any) begin
      flag_n_reg <= 1'b1;
    end
  end

  // Readback pointer for the next frame
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      ptr_sel_reg <= RB_B1_CODE;
      ptr_ch_reg  <= 2'h0;
    end else if (exec) begin
      ptr_sel_reg <= ptr_sel_next;
      ptr_ch_reg  <= (addr == ADDR_ALL) ? 2'h0 : addr[2:1];
    end
  end

  // Header is complete on the edge that shifts its last address bit
  assign hdr_done    = (frame_reg == FS_SHIFT) && sck_rise && !cs_rise && (cnt_next == hdr_len);
  assign hdr_cmd     = shift_next[7:4];
  assign hdr_addr    = shift_next[3:0];
  assign hdr_is_read = (hdr_cmd >= CMD_RD_B1_SPAN) && (hdr_cmd <= CMD_RD_B2_CODE);

  always_comb begin
    rb_sel = ptr_sel_reg;
    rb_ch  = ptr_ch_reg;
    if (hdr_is_read) begin
      rb_sel = qdsc_rbsel_t'(hdr_cmd[1:0] - CMD_RD_B1_SPAN[1:0]);
      rb_ch  = (hdr_addr == ADDR_ALL) ? 2'h0 : hdr_addr[2:1];
    end
    rb_word = '0;
    case (rb_sel)
      RB_B1_SPAN: begin
        rb_word[SPAN_W-1:0]   = hold_span_reg[rb_ch];
        rb_word[SLEEP_BIT_POS] = sleep_reg[rb_ch];
      end
      RB_B1_CODE: rb_word = hold_code_reg[rb_ch];
      RB_B2_SPAN: begin
        rb_word[SPAN_W-1:0]   = act_span_reg[rb_ch];
        rb_word[SLEEP_BIT_POS] = sleep_reg[rb_ch];
      end
      RB_B2_CODE: rb_word = act_code_reg[rb_ch];
      default: rb_word = '0;
    endcase
  end

  // Readback shifter, new bit presented on each falling serial clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      rb_reg        <= '0;
      rb_active_reg <= 1'b0;
      sro_reg       <= 1'b0;
    end else if (clr_act || frame_reg != FS_SHIFT || cs_fall) begin
      rb_reg        <= '0;
      rb_active_reg <= 1'b0;
      sro_reg       <= 1'b0;
    end else if (hdr_done) begin
      rb_reg        <= rb_word;
      rb_active_reg <= 1'b1;
    end else if (sck_fall && rb_active_reg) begin
      sro_reg <= rb_reg[CODE_W-1];
      rb_reg  <= {rb_reg[CODE_W-2:0], 1'b0};
    end
  end

  assign SERIAL_READBACK_OUT_O = sro_reg;
  assign SERIAL_READBACK_OE_O  = ~sync2_reg[SY_CS];
  assign DATA_LOSS_FLAG_N_O    = flag_n_reg;
  assign ACT_CODE_A_O          = act_code_reg[0];
  assign ACT_CODE_B_O          = act_code_reg[1];
  assign ACT_CODE_C_O          = act_code_reg[2];
  assign ACT_CODE_D_O          = act_code_reg[3];
  assign ACT_SPAN_A_O          = act_span_reg[0];
  assign ACT_SPAN_B_O          = act_span_reg[1];
  assign ACT_SPAN_C_O          = act_span_reg[2];
  assign ACT_SPAN_D_O          = act_span_reg[3];
  assign CH_SLEEP_O            = sleep_reg;
  assign REF_AMP_AB_PD_O       = sleep_reg[0] & sleep_reg[1];
  assign REF_AMP_CD_PD_O       = sleep_reg[2] & sleep_reg[3];

endmodule : qdsc_top

/* test/qdsc_top_monitor.sv */
// Purpose: Port checks for the quad DAC serial control block
// Assumes: Two-flop sync on every asynchronous pin
// Notes:   Bound into qdsc_top after the module
module qdsc_top_monitor
  import qdsc_pkg::*;
(
  input wire logic              CORE_CLK_I,
  input wire logic              RESET_I,
  input wire logic              SELECT_LOAD_STROBE_N_I,
  input wire logic              ASYNC_UPDATE_PIN_N_I,
  input wire logic              SYSTEM_CLEAR_N_I,
  input wire logic              VDD_LOW_I,
  input wire logic              SERIAL_READBACK_OUT_O,
  input wire logic              SERIAL_READBACK_OE_O,
  input wire logic              DATA_LOSS_FLAG_N_O,
  input wire logic [CODE_W-1:0] ACT_CODE_A_O,
  input wire logic [SPAN_W-1:0] ACT_SPAN_A_O,
  input wire logic [NUM_CH-1:0] CH_SLEEP_O,
  input wire logic              REF_AMP_AB_PD_O,
  input wire logic              REF_AMP_CD_PD_O
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  // No strobe, load or clear activity
  sequence s_quiet;
    (SELECT_LOAD_STROBE_N_I && ASYNC_UPDATE_PIN_N_I && SYSTEM_CLEAR_N_I)[*8];
  endsequence
  // Clean load-pin pulse with strobe high
  sequence s_load;
    (SELECT_LOAD_STROBE_N_I && SYSTEM_CLEAR_N_I && !VDD_LOW_I && ASYNC_UPDATE_PIN_N_I)[*3]
      ##1 (SELECT_LOAD_STROBE_N_I && SYSTEM_CLEAR_N_I && !VDD_LOW_I && !ASYNC_UPDATE_PIN_N_I)[*4];
  endsequence

  property p_oe_float;
    SELECT_LOAD_STROBE_N_I[*3] |=> !SERIAL_READBACK_OE_O;
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("readback driven while strobe high");
  property p_lead_low;
    $rose(SERIAL_READBACK_OE_O) |-> !SERIAL_READBACK_OUT_O[*8];
  endproperty
  a_lead_low: assert property (p_lead_low) else $error("readback not low before data");
  property p_amp_ab;
    REF_AMP_AB_PD_O == (CH_SLEEP_O[0] && CH_SLEEP_O[1]);
  endproperty
  a_amp_ab: assert property (p_amp_ab) else $error("pair AB amplifier state wrong");
  property p_amp_cd;
    REF_AMP_CD_PD_O == (CH_SLEEP_O[2] && CH_SLEEP_O[3]);
  endproperty
  a_amp_cd: assert property (p_amp_cd) else $error("pair CD amplifier state wrong");
  property p_clear_zero;
    !SYSTEM_CLEAR_N_I[*4] |=> (ACT_CODE_A_O == 16'h0000) && (ACT_SPAN_A_O == 4'h0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("active not zero under clear");
  property p_flag_set;
    (!SYSTEM_CLEAR_N_I || VDD_LOW_I)[*4] |=> !DATA_LOSS_FLAG_N_O;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not asserted");
  property p_flag_hold;
    s_quiet ##0 !DATA_LOSS_FLAG_N_O |=> !DATA_LOSS_FLAG_N_O;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag released without update");
  property p_act_stable;
    s_quiet |=> $stable(ACT_CODE_A_O) && $stable(ACT_SPAN_A_O);
  endproperty
  a_act_stable: assert property (p_act_stable) else $error("active changed without update");
  property p_load_wake;
    s_load |-> ##[0:4] ((CH_SLEEP_O == MASK_NONE) && DATA_LOSS_FLAG_N_O);
  endproperty
  a_load_wake: assert property (p_load_wake) else $error("load pulse did not wake or release");
endmodule : qdsc_top_monitor

bind qdsc_top qdsc_top_monitor qdsc_top_monitor_inst (
  .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .SELECT_LOAD_STROBE_N_I(SELECT_LOAD_STROBE_N_I),
  .ASYNC_UPDATE_PIN_N_I(ASYNC_UPDATE_PIN_N_I), .SYSTEM_CLEAR_N_I(SYSTEM_CLEAR_N_I), .VDD_LOW_I(VDD_LOW_I),
  .SERIAL_READBACK_OUT_O(SERIAL_READBACK_OUT_O), .SERIAL_READBACK_OE_O(SERIAL_READBACK_OE_O),
  .DATA_LOSS_FLAG_N_O(DATA_LOSS_FLAG_N_O), .ACT_CODE_A_O(ACT_CODE_A_O), .ACT_SPAN_A_O(ACT_SPAN_A_O),
  .CH_SLEEP_O(CH_SLEEP_O), .REF_AMP_AB_PD_O(REF_AMP_AB_PD_O), .REF_AMP_CD_PD_O(REF_AMP_CD_PD_O)
);

/* test/qdsc_host_model.sv */
// Purpose: Host serial master model for the quad DAC control block
// Assumes: Four core cycles per serial half period, driven on falling core edges
// Notes:   SCK idles low between frames; SDI flips when a frame ends
module qdsc_host_model (
  input  wire logic clk_i,
  input  wire logic sro_i,
  input  wire logic sro_oe_i,
  output logic      sck_o,
  output logic      sdi_o,
  output logic      strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    strobe_n_o = 1'b1;
  end

  task automatic half_bit();
    repeat (4) @(negedge clk_i);
  endtask : half_bit

  // Shift nbits MSB first, keep the last 16 readback bits
  task automatic xfer(input logic [31:0] word, input logic [5:0] nbits, output logic [15:0] rb);
    int hdr;
    hdr = int'(nbits) - 16;
    rb = 16'h0000;
    @(negedge clk_i);
    strobe_n_o = 1'b0;
    half_bit();
    for (int i = int'(nbits) - 1; i >= 0; i--) begin
      sdi_o = word[i];
      half_bit();
      sck_o = 1'b1;
      half_bit();
      if (int'(nbits) - i > hdr) begin
        rb = {rb[14:0], sro_oe_i ? sro_i : 1'bx};
      end
      sck_o = 1'b0;
    end
    half_bit();
    strobe_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (6) @(negedge clk_i);
  endtask : xfer
endmodule : qdsc_host_model

/* test/qdsc_top_tb.sv */
// Purpose: Self-checking bench for the quad DAC serial control block
// Assumes: Host model shifts one bit per 160 ns
// Notes:   Table of frames first, then load pin, clear abort and reset cases
module qdsc_top_tb
  import qdsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [31:0]      word;
    logic [CNT_W-1:0] nbits;
    logic             f32;
    logic             chk;
    logic [15:0]      rb;
    logic [15:0]      spans;
    logic [3:0]       sleep_status_bit;
  } qdsc_row_t;

  localparam qdsc_row_t ROWS [23] = '{
    '{32'h002f0003, FRAME_LEN_24, 1'b0, 1'b1, 16'h0000, 16'h0000, 4'h0},
    '{32'h00200001, FRAME_LEN_24, 1'b0, 1'b1, 16'h0003, 16'h0000, 4'h0},
    '{32'h003f8000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0001, 16'h0000, 4'h0},
    '{32'h00300000, FRAME_LEN_24, 1'b0, 1'b1, 16'h8000, 16'h0000, 4'h0},
    '{32'h004f0000, 6'h17,        1'b0, 1'b0, 16'h0000, 16'h0000, 4'h0},
    '{32'h004f1234, FRAME_LEN_24, 1'b0, 1'b1, 16'h0000, 16'h3331, 4'h0},
    '{32'h00e20000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0001, 16'h3331, 4'h2},
    '{32'h00e00000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0013, 16'h3331, 4'h3},
    '{32'h00c00000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0011, 16'h3331, 4'h3},
    '{32'ha5348000, FRAME_LEN_32, 1'b1, 1'b1, 16'h0011, 16'h3331, 4'h3},
    '{32'hff240004, FRAME_LEN_32, 1'b1, 1'b1, 16'h8000, 16'h3331, 4'h3},
    '{32'h00a40000, FRAME_LEN_32, 1'b1, 1'b1, 16'h0004, 16'h3331, 4'h3},
    '{32'h5a440000, FRAME_LEN_32, 1'b1, 1'b1, 16'h0004, 16'h3431, 4'h3},
    '{32'h000f0005, FRAME_LEN_24, 1'b0, 1'b1, 16'h0004, 16'h3431, 4'h3},
    '{32'h00210002, FRAME_LEN_24, 1'b0, 1'b1, 16'h0004, 16'h3431, 4'h3},
    '{32'h00f00000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0004, 16'h3431, 4'h3},
    '{32'h00761234, FRAME_LEN_24, 1'b0, 1'b1, 16'h0000, 16'h3431, 4'h3},
    '{32'h00d60000, FRAME_LEN_24, 1'b0, 1'b1, 16'h1234, 16'h3431, 4'h3},
    '{32'h00620003, FRAME_LEN_24, 1'b0, 1'b1, 16'h1234, 16'h3431, 4'h1},
    '{32'h00500000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0003, 16'h3431, 4'h0},
    '{32'h00968000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0000, 16'h3431, 4'h0},
    '{32'h00840004, FRAME_LEN_24, 1'b0, 1'b1, 16'h8000, 16'h3431, 4'h0},
    '{32'h00ef0000, FRAME_LEN_24, 1'b0, 1'b1, 16'h0004, 16'h3431, 4'hf}
  };

  logic              clk;
  logic              rst;
  logic              async_update_pin_n_n;
  logic              clr_n;
  logic              vdd_low;
  logic              f32;
  logic              sck;
  logic              sdi;
  logic              cs_n;
  logic              serial_readback_out;
  logic              sro_oe;
  logic              flag_n;
  logic [CODE_W-1:0] code_a, code_b, code_c, code_d;
  logic [SPAN_W-1:0] span_a, span_b, span_c, span_d;
  logic [NUM_CH-1:0] sleep_status_bit;
  logic              amp_ab;
  logic              amp_cd;
  logic [15:0]       rb;
  int                n_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;

  qdsc_top qdsc_top_inst (
    .CORE_CLK_I(clk), .RESET_I(rst), .SCK_I(sck), .SDI_I(sdi), .SELECT_LOAD_STROBE_N_I(cs_n),
    .ASYNC_UPDATE_PIN_N_I(async_update_pin_n_n), .SYSTEM_CLEAR_N_I(clr_n), .VDD_LOW_I(vdd_low), .FRAME_32_I(f32),
    .SERIAL_READBACK_OUT_O(serial_readback_out), .SERIAL_READBACK_OE_O(sro_oe), .DATA_LOSS_FLAG_N_O(flag_n),
    .ACT_CODE_A_O(code_a), .ACT_CODE_B_O(code_b), .ACT_CODE_C_O(code_c), .ACT_CODE_D_O(code_d),
    .ACT_SPAN_A_O(span_a), .ACT_SPAN_B_O(span_b), .ACT_SPAN_C_O(span_c), .ACT_SPAN_D_O(span_d),
    .CH_SLEEP_O(sleep_status_bit), .REF_AMP_AB_PD_O(amp_ab), .REF_AMP_CD_PD_O(amp_cd)
  );

  qdsc_host_model qdsc_host_model_inst (
    .clk_i(clk), .sro_i(serial_readback_out), .sro_oe_i(sro_oe), .sck_o(sck), .sdi_o(sdi), .strobe_n_o(cs_n)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic pulse_load();
    @(negedge clk);
    async_update_pin_n_n = 1'b0;
    repeat (6) @(negedge clk);
    async_update_pin_n_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : pulse_load

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    async_update_pin_n_n = 1'b1;
    clr_n = 1'b1;
    vdd_low = 1'b0;
    f32 = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 23; i++) begin
      f32 = ROWS[i].f32;
      repeat (2) @(negedge clk);
      qdsc_host_model_inst.xfer(ROWS[i].word, ROWS[i].nbits, rb);
      if (ROWS[i].chk) begin
        check(rb, ROWS[i].rb);
      end
      check({span_d, span_c, span_b, span_a}, ROWS[i].spans);
      check({12'h000, sleep_status_bit}, {12'h000, ROWS[i].sleep_status_bit});
      $display("row %0d done", i);
    end
    check(code_a, 16'h0000);
    check(code_c, 16'h8000);
    check(code_b, 16'h8000);
    check(code_d, 16'h8000);
    check({14'h0000, amp_ab, amp_cd}, 16'h0003);
    check({15'h0000, flag_n}, 16'h0001);
    vdd_low = 1'b1;
    repeat (6) @(negedge clk);
    vdd_low = 1'b0;
    qdsc_host_model_inst.xfer(32'h00301234, FRAME_LEN_24, rb);
    check({15'h0000, flag_n}, 16'h0000);
    check(code_a, 16'h0000);
    pulse_load();
    check(code_a, 16'h1234);
    check({8'h00, sleep_status_bit, 3'h0, flag_n}, 16'h0001);
    $display("load pin test done");
    fork
      qdsc_host_model_inst.xfer(32'h004f0000, FRAME_LEN_24, rb);
      begin
        repeat (90) @(negedge clk);
        clr_n = 1'b0;
        repeat (6) @(negedge clk);
        clr_n = 1'b1;
      end
    join
    check(code_a, 16'h0000);
    check({span_d, span_c, span_b, span_a}, 16'h0000);
    check({15'h0000, flag_n}, 16'h0000);
    qdsc_host_model_inst.xfer(32'h00b00000, FRAME_LEN_24, rb);
    check(rb, 16'h1234);
    pulse_load();
    check({span_d, span_c, span_b, span_a}, 16'h3431);
    $display("clear abort test done");
    rst = 1'b1;
    repeat (8) @(negedge clk);
    check(code_a, 16'h0000);
    check({span_d, span_c, span_b, span_a}, 16'h0000);
    check({11'h000, flag_n, sleep_status_bit}, 16'h0000);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    qdsc_host_model_inst.xfer(32'h00b00000, FRAME_LEN_24, rb);
    check(rb, 16'h0000);
    $display("reset test done");
    complete_run();
  end
endmodule : qdsc_top_tb
